// ===== hw/uas_pkg.sv
// Package: register map, field layouts, reset values and state codes of the serial unit
package uas_pkg;

  // ==========================================================
  // Register map (byte addresses on the bus)
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_TXHOLD = 5'h08;
  localparam logic [4:0] OFS_RXHOLD = 5'h0c;
  localparam logic [4:0] OFS_BAUD   = 5'h10;

  // ==========================================================
  // Control register layout, bit 0 is txEmptyIrqEn
  typedef struct packed {
    logic parEn;
    logic portLevel;
    logic portDir;
    logic halfOvs;
    logic syncMode;
    logic clkSrcSelHi;
    logic clkSrcSelLo;
    logic rxOn;
    logic txOn;
    logic txDoneIrqEn;
    logic rxIrqEn;
    logic txEmptyIrqEn;
  } uas_ctrl_type;

  // Status register layout, bit 0 is txEmpty
  typedef struct packed {
    logic parityFault;
    logic frameFault;
    logic overrunFlag;
    logic rxFull;
    logic txDone;
    logic txEmpty;
  } uas_status_type;

  localparam uas_ctrl_type   CTRL_RST   = 12'h000;
  localparam uas_status_type STATUS_RST = 6'h03;
  localparam logic [15:0]    BAUD_RST   = 16'h0000;

  // ==========================================================
  // Oversampling: last basic-clock index of a bit and the latch point
  localparam logic [3:0] OVS_LAST_FULL = 4'hf;
  localparam logic [3:0] OVS_LAST_HALF = 4'h7;
  localparam logic [3:0] LATCH_FULL    = 4'h7;
  localparam logic [3:0] LATCH_HALF    = 4'h3;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // ==========================================================
  // State codes
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } uas_tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } uas_rx_state_type;

endpackage

// ===== hw/uas_top.sv
// Serial unit: Wishbone registers, transmitter, receiver, pin muxing and interrupt requests
module uas_top
  import uas_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxPin,
  output logic             txPinOut,
  output logic             txPinOe,
  output logic             serialClkOut,
  output logic             serialClkOe,
  output logic             rxFullIrq,
  output logic             txEmptyIrq,
  output logic             txDoneIrq,
  output logic             rxErrIrq
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] ovsLast(input logic half);
    ovsLast = half ? OVS_LAST_HALF : OVS_LAST_FULL;
  endfunction

  uas_ctrl_type     ctrl;
  uas_status_type   stat;
  uas_tx_state_type txState;
  uas_rx_state_type rxState;
  logic [15:0] baudDiv;
  logic [15:0] divCnt;
  logic        basicTick;
  logic [7:0]  txHold;
  logic [7:0]  txShift;
  logic [3:0]  txSub;
  logic [2:0]  txBit;
  logic        txPar;
  logic [7:0]  rxShift;
  logic [7:0]  rxHold;
  logic [3:0]  rxSub;
  logic [2:0]  rxBit;
  logic        rxParBit;
  logic        rxMeta;
  logic        rxSync;
  logic        clkActivePrev;
  logic        wbReq;
  logic        txHoldWr;
  logic        rxHoldRd;
  logic        statWr;
  logic        anyErr;
  logic        txLoad;
  logic        txBitEnd;
  logic        txLastBit;
  logic        txEndOk;
  logic        txLine;
  logic        rxSample;
  logic        rxFinish;
  logic        rxFe;
  logic        rxPe;
  logic        rxOe;
  logic        rxGood;
  logic        clkActive;
  logic        clkLow;
  logic        clkGlitch;

  // ==========================================================
  // Bus slave: one wait state, ack drops the cycle after it is given
  assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign txHoldWr = wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_TXHOLD;
  assign rxHoldRd = wbReq && !wb_we_i && wb_adr_i == OFS_RXHOLD;
  assign statWr   = wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_STATUS;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          OFS_CTRL:   wb_dat_o <= {20'h0, ctrl};
          OFS_STATUS: wb_dat_o <= {26'h0, stat};
          OFS_RXHOLD: wb_dat_o <= {24'h0, rxHold};
          OFS_BAUD:   wb_dat_o <= {16'h0, baudDiv};
          default:    wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Control and divider writes honour byte lanes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl    <= CTRL_RST;
      baudDiv <= BAUD_RST;
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_CTRL && wb_sel_i[1]) ctrl[11:8] <= wb_dat_i[11:8];
      if (wb_adr_i == OFS_BAUD && wb_sel_i[0]) baudDiv[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_BAUD && wb_sel_i[1]) baudDiv[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) txHold <= 8'h0;
    else if (txHoldWr) txHold <= wb_dat_i[7:0];
  end

  // ==========================================================
  // Basic clock: one tick every baudDiv+1 system clocks
  always_ff @(posedge sys_clk) begin
    if (reset || divCnt == baudDiv) divCnt <= 16'h0;
    else divCnt <= divCnt + 16'h1;
  end
  assign basicTick = divCnt == baudDiv;

  // ==========================================================
  // Transmitter; sync mode drops start and stop bits
  assign anyErr    = stat.overrunFlag || stat.frameFault || stat.parityFault;
  assign txLoad    = txState == TX_IDLE && !stat.txEmpty && ctrl.txOn
                     && !(ctrl.syncMode && anyErr);
  assign txBitEnd  = basicTick && txSub == ovsLast(ctrl.halfOvs);
  assign txLastBit = txBitEnd && (txState == TX_STOP || txState == TX_PAR
                     && ctrl.syncMode || txState == TX_DATA && txBit == LAST_DATA_BIT
                     && ctrl.syncMode && !ctrl.parEn);
  assign txEndOk   = txLastBit && stat.txEmpty;

  always_ff @(posedge sys_clk) begin
    if (reset || !ctrl.txOn) begin
      txState <= TX_IDLE;
      txSub   <= 4'h0;
      txBit   <= 3'h0;
      txShift <= 8'h0;
      txPar   <= 1'b0;
    end else begin
      txSub <= txState == TX_IDLE || txBitEnd ? 4'h0 : txSub + (basicTick ? 4'h1 : 4'h0);
      unique case (txState)
        TX_IDLE: if (txLoad) begin
          txShift <= txHold;
          txPar   <= ^txHold;
          txBit   <= 3'h0;
          txState <= ctrl.syncMode ? TX_DATA : TX_START;
        end
        TX_START: if (txBitEnd) txState <= TX_DATA;
        TX_DATA: if (txBitEnd) begin
          txShift <= {1'b0, txShift[7:1]};
          txBit   <= txBit + 3'h1;
          if (txBit == LAST_DATA_BIT)
            txState <= ctrl.parEn ? TX_PAR : (ctrl.syncMode ? TX_IDLE : TX_STOP);
        end
        TX_PAR: if (txBitEnd) txState <= ctrl.syncMode ? TX_IDLE : TX_STOP;
        TX_STOP: if (txBitEnd) txState <= TX_IDLE;
        default: txState <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    unique case (txState)
      TX_START: txLine = 1'b0;
      TX_DATA:  txLine = txShift[0];
      TX_PAR:   txLine = txPar;
      default:  txLine = 1'b1;
    endcase
  end

  // ==========================================================
  // Receiver: two-stage sync, then oversampled framing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxPin;
      rxSync <= rxMeta;
    end
  end

  assign rxSample = basicTick && rxState != RX_IDLE
                    && rxSub == (ctrl.halfOvs ? LATCH_HALF : LATCH_FULL);
  assign rxFinish = rxSample && rxState == RX_STOP;
  assign rxFe     = !rxSync;
  assign rxPe     = ctrl.parEn && (^rxShift != rxParBit);
  assign rxOe     = stat.rxFull;
  assign rxGood   = rxFinish && !rxFe && !rxPe && !rxOe;

  // A low line in idle starts a frame, so a break keeps producing frames
  always_ff @(posedge sys_clk) begin
    if (reset || !ctrl.rxOn) begin
      rxState  <= RX_IDLE;
      rxSub    <= 4'h0;
      rxBit    <= 3'h0;
      rxShift  <= 8'h0;
      rxParBit <= 1'b0;
    end else begin
      if (rxState == RX_IDLE) rxSub <= 4'h0;
      else if (basicTick) rxSub <= rxSub == ovsLast(ctrl.halfOvs) ? 4'h0 : rxSub + 4'h1;
      unique case (rxState)
        RX_IDLE:  if (basicTick && !rxSync) rxState <= RX_START;
        RX_START: if (rxSample) begin
          rxState <= rxSync ? RX_IDLE : RX_DATA;
          rxBit   <= 3'h0;
        end
        RX_DATA: if (rxSample) begin
          rxShift <= {rxSync, rxShift[7:1]};
          rxBit   <= rxBit + 3'h1;
          if (rxBit == LAST_DATA_BIT) rxState <= ctrl.parEn ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rxSample) begin
          rxParBit <= rxSync;
          rxState  <= RX_STOP;
        end
        RX_STOP: if (rxSample) rxState <= RX_IDLE;
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) rxHold <= 8'h0;
    else if (rxGood) rxHold <= rxShift;
  end

  // ==========================================================
  // Status flags; hardware set wins over any clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) stat <= STATUS_RST;
    else begin
      if (!ctrl.txOn || txLoad) stat.txEmpty <= 1'b1;
      else if (txHoldWr) stat.txEmpty <= 1'b0;
      if (!ctrl.txOn || txEndOk) stat.txDone <= 1'b1;
      else if (txLoad) stat.txDone <= 1'b0;
      if (rxGood) stat.rxFull <= 1'b1;
      else if (rxHoldRd) stat.rxFull <= 1'b0;
      // Errors clear only by writing 1, never by rxOn
      if (rxFinish && rxOe) stat.overrunFlag <= 1'b1;
      else if (statWr && wb_dat_i[3]) stat.overrunFlag <= 1'b0;
      if (rxFinish && rxFe) stat.frameFault <= 1'b1;
      else if (statWr && wb_dat_i[4]) stat.frameFault <= 1'b0;
      if (rxFinish && rxPe) stat.parityFault <= 1'b1;
      else if (statWr && wb_dat_i[5]) stat.parityFault <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt requests: registered levels of flag and enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxFullIrq  <= 1'b0;
      txEmptyIrq <= 1'b0;
      txDoneIrq  <= 1'b0;
      rxErrIrq   <= 1'b0;
    end else begin
      rxFullIrq  <= stat.rxFull && ctrl.rxIrqEn;
      txEmptyIrq <= stat.txEmpty && ctrl.txEmptyIrqEn;
      txDoneIrq  <= stat.txDone && ctrl.txDoneIrqEn;
      rxErrIrq   <= anyErr && ctrl.rxIrqEn;
    end
  end

  // ==========================================================
  // Pins; the clock pin low pulse lasts one system clock, the finest step here
  assign clkActive = ctrl.syncMode && !ctrl.clkSrcSelHi && (ctrl.txOn || ctrl.rxOn);
  assign clkLow    = txState == TX_DATA && txSub <= (ctrl.halfOvs ? LATCH_HALF : LATCH_FULL);
  assign clkGlitch = clkActivePrev && !clkActive && !ctrl.clkSrcSelHi;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txPinOut      <= 1'b1;
      txPinOe       <= 1'b0;
      serialClkOut  <= 1'b1;
      serialClkOe   <= 1'b0;
      clkActivePrev <= 1'b0;
    end else begin
      txPinOut      <= ctrl.txOn ? txLine : ctrl.portLevel;
      txPinOe       <= ctrl.txOn || ctrl.portDir;
      clkActivePrev <= clkActive;
      serialClkOut  <= clkActive && !clkLow;
      serialClkOe   <= clkActive || clkGlitch;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_RESET_FLAGS: assert property ($past(reset) && !reset |-> stat.txEmpty && stat.txDone)
    else $error("empty or done flag not 1 after reset");
  AST_TXE_IRQ: assert property (stat.txEmpty && ctrl.txEmptyIrqEn |=> txEmptyIrq)
    else $error("transmit empty request missing");
  AST_LOAD_EMPTY: assert property (txLoad |=> stat.txEmpty && txState != TX_IDLE)
    else $error("load did not set empty flag");
  AST_DONE: assert property (txEndOk && ctrl.txDoneIrqEn |=> stat.txDone ##1 txDoneIrq)
    else $error("transmit done not raised");
  AST_RX_GOOD: assert property (rxGood |=> stat.rxFull && rxHold == $past(rxShift))
    else $error("received byte not moved to hold");
  AST_ERR_IRQ: assert property (anyErr && ctrl.rxIrqEn |=> rxErrIrq)
    else $error("receive error request missing");
  AST_MASK: assert property (!ctrl.rxIrqEn |=> !rxFullIrq && !rxErrIrq)
    else $error("receive request not masked");
  AST_TX_OFF: assert property (!ctrl.txOn |=> txState == TX_IDLE && txPinOut == $past(ctrl.portLevel)
                               && txPinOe == $past(ctrl.portDir))
    else $error("transmit pin not handed to port");
  AST_SYNC_BLOCK: assert property (ctrl.syncMode && anyErr |-> !txLoad)
    else $error("transmission started with error flag");
  AST_ERR_HOLD: assert property (stat.frameFault && !(statWr && wb_dat_i[4]) |=> stat.frameFault)
    else $error("framing fault lost");
  AST_TXHOLD_WR: assert property (txHoldWr && !txLoad && ctrl.txOn |=> !stat.txEmpty)
    else $error("hold write did not clear empty flag");
  AST_RXHOLD_RD: assert property (rxHoldRd && !rxGood |=> !stat.rxFull)
    else $error("hold read did not clear full flag");
  AST_GLITCH: assert property (clkGlitch |=> serialClkOe && !serialClkOut)
    else $error("clock pin switch pulse missing");

  COV_RX_FRAME: cover property (rxGood ##[1:1000] rxHoldRd);
  COV_BREAK:    cover property (rxFinish && rxFe ##[1:1000] rxFinish && rxFe);
  COV_TX_CHAIN: cover property (txLoad ##[1:1000] txHoldWr ##[1:1000] txLoad);

endmodule

// ===== verif/uas_remote_station.sv
// Remote serial station: sends frames on the receive line, captures frames from the transmit pin
module uas_remote_station (
  input  wire logic sys_clk,
  input  wire logic txLine,
  input  wire logic txLineOe,
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 1ps;

  int         bitClks   = 16;
  int         byteCount = 0;
  logic [7:0] lastByte  = 8'h00;
  logic       parMode   = 1'b0;
  logic [7:0] sh;
  logic       lineLvl;

  // A released transmit pin reads as mark through the line pull-up
  assign lineLvl = txLineOe ? txLine : 1'b1;

  initial rxLine = 1'b1;

  // ==========================================================
  // Sender: start 0, eight bits LSB first, parity bit p when parMode is set, stop 1
  task automatic send_byte(input logic [7:0] b, input logic p);
    logic [10:0] f;
    f = parMode ? {1'b1, p, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < (parMode ? 11 : 10); i++) begin
      @(posedge sys_clk);
      rxLine <= f[i];
      repeat (bitClks - 1) @(posedge sys_clk);
    end
  endtask

  // Holds the line at a level, low for a break
  task automatic set_line(input logic lvl);
    @(posedge sys_clk);
    rxLine <= lvl;
  endtask

  // ==========================================================
  // Capture: sync on the start edge, sample mid-bit
  always begin
    @(posedge sys_clk);
    if (lineLvl === 1'b0) begin
      repeat (bitClks / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitClks) @(posedge sys_clk);
        sh[i] = lineLvl;
      end
      repeat (bitClks) @(posedge sys_clk);
      lastByte = sh;
      byteCount++;
    end
  end
endmodule

// ===== verif/uas_top_tb_top.sv
// Testbench: registers, transmit, receive, break and port fallback of the serial unit
module uas_top_tb_top
  import uas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [4:0]  wbAdr   = 5'h00;
  logic [3:0]  wbSel   = 4'h0;
  logic [31:0] wbDat   = 32'h0;
  logic [31:0] wbDatO;
  logic [31:0] rd;
  logic        wbAck;
  logic        rxPin;
  logic        txPinOut;
  logic        txPinOe;
  logic        serClkOut;
  logic        serClkOe;
  logic        rxFullIrq;
  logic        txEmptyIrq;
  logic        txDoneIrq;
  logic        rxErrIrq;
  logic [3:0]  irqs;
  int          err_count   = 0;
  int          checks_done = 0;

  assign irqs = {rxErrIrq, txDoneIrq, txEmptyIrq, rxFullIrq};

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  uas_top i_dut (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe), .serialClkOut(serClkOut), .serialClkOe(serClkOe),
    .rxFullIrq(rxFullIrq), .txEmptyIrq(txEmptyIrq), .txDoneIrq(txDoneIrq), .rxErrIrq(rxErrIrq)
  );

  uas_remote_station i_remote (
    .sys_clk(sys_clk), .txLine(txPinOut), .txLineOe(txPinOe), .rxLine(rxPin)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Classic single cycle; holds the request until ack is sampled high, the watchdog bounds the wait
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= 4'hf;
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    check({31'h0, wbAck}, 32'h1);
  endtask

  // Bounded wait for a request line to reach a level
  task automatic wait_irq(input int k, input logic lvl);
    int n;
    n = 0;
    while (irqs[k] !== lvl && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    check({31'h0, irqs[k]}, {31'h0, lvl});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check({28'h0, irqs}, 32'h0);
    bus(0, OFS_STATUS, 32'h0);
    check(rd, 32'h3);
    bus(1, 5'h14, 32'hff);
    bus(0, 5'h14, 32'h0);
    check(rd, 32'h0);
    bus(1, OFS_CTRL, 32'h5);
    wait_irq(1, 1'b1);
    wait_irq(2, 1'b1);
    bus(1, OFS_CTRL, 32'h0);
    wait_irq(1, 1'b0);
    wait_irq(2, 1'b0);
    $display("Test reset done");
  endtask

  // Second byte written while the first shifts out
  task automatic t_tx();
    bus(1, OFS_CTRL, 32'hd);
    bus(1, OFS_TXHOLD, 32'ha5);
    bus(0, OFS_STATUS, 32'h0);
    check(rd, 32'h1);
    bus(1, OFS_TXHOLD, 32'h5a);
    bus(0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    wait_irq(2, 1'b1);
    check({24'h0, i_remote.lastByte}, 32'h5a);
    check(i_remote.byteCount, 32'h2);
    bus(1, OFS_CTRL, 32'h0);
    $display("Test transmit done");
  endtask

  task automatic t_rx(input logic h);
    logic [7:0] b;
    b = h ? 8'hc3 : 8'h3c;
    i_remote.bitClks = h ? 8 : 16;
    bus(1, OFS_CTRL, h ? 32'h112 : 32'h12);
    i_remote.send_byte(b, 1'b0);
    wait_irq(0, 1'b1);
    bus(0, OFS_RXHOLD, 32'h0);
    check(rd, {24'h0, b});
    wait_irq(0, 1'b0);
    check({31'h0, rxErrIrq}, 32'h0);
    i_remote.bitClks = 16;
    $display("Test receive done");
  endtask

  // Even parity accepted; wrong parity on top of an unread byte raises parity and overrun
  task automatic t_par();
    i_remote.parMode = 1'b1;
    bus(1, OFS_CTRL, 32'h812);
    i_remote.send_byte(8'h3c, 1'b0);
    wait_irq(0, 1'b1);
    i_remote.send_byte(8'h3c, 1'b1);
    wait_irq(3, 1'b1);
    bus(0, OFS_STATUS, 32'h0);
    check(rd, 32'h2f);
    bus(0, OFS_RXHOLD, 32'h0);
    check(rd, 32'h3c);
    bus(1, OFS_STATUS, 32'h38);
    wait_irq(3, 1'b0);
    wait_irq(0, 1'b0);
    i_remote.parMode = 1'b0;
    $display("Test parity done");
  endtask

  // Held break, then synchronous transmit blocked by error flags
  task automatic t_break();
    bus(1, OFS_CTRL, 32'h12);
    i_remote.set_line(1'b0);
    wait_irq(3, 1'b1);
    bus(1, OFS_STATUS, 32'h38);
    wait_irq(3, 1'b0);
    wait_irq(3, 1'b1);
    bus(1, OFS_CTRL, 32'h2);
    i_remote.set_line(1'b1);
    bus(0, OFS_STATUS, 32'h0);
    check(rd & 32'h14, 32'h10);
    bus(1, OFS_CTRL, 32'h88);
    bus(1, OFS_TXHOLD, 32'h77);
    repeat (4) @(posedge sys_clk);
    bus(0, OFS_STATUS, 32'h0);
    check(rd & 32'h1, 32'h0);
    bus(1, OFS_CTRL, 32'hc0);
    @(posedge sys_clk);
    check({30'h0, serClkOe, serClkOut}, 32'h0);
    bus(1, OFS_STATUS, 32'h38);
    // Leaving clock output with the source select low gives one low pulse
    bus(1, OFS_CTRL, 32'h88);
    bus(1, OFS_CTRL, 32'h80);
    @(posedge sys_clk);
    check({30'h0, serClkOe, serClkOut}, 32'h2);
    @(posedge sys_clk);
    check({31'h0, serClkOe}, 32'h0);
    bus(1, OFS_CTRL, 32'h0);
    $display("Test break done");
  endtask

  // Port fallback, mark and break sending
  task automatic t_port();
    bus(1, OFS_CTRL, 32'h600);
    repeat (2) @(posedge sys_clk);
    check({30'h0, txPinOe, txPinOut}, 32'h3);
    bus(1, OFS_CTRL, 32'h608);
    bus(1, OFS_TXHOLD, 32'h0);
    repeat (40) @(posedge sys_clk);
    check({31'h0, txPinOut}, 32'h0);
    bus(1, OFS_CTRL, 32'h208);
    bus(1, OFS_CTRL, 32'h200);
    repeat (2) @(posedge sys_clk);
    check({30'h0, txPinOe, txPinOut}, 32'h2);
    bus(0, OFS_STATUS, 32'h0);
    check(rd, 32'h3);
    bus(1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, txPinOe}, 32'h0);
    $display("Test port done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_tx();
    t_rx(1'b0);
    t_rx(1'b1);
    t_par();
    t_break();
    t_port();
    report_and_stop();
  end

  // Watchdog: the tests need under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end
endmodule
